// ---- rtl/crcp_defines.svh ----
// constants for the fifo crc coprocessor: offsets, fields, codes
// assumes inclusion by the package and the top module only
`ifndef CRCP_DEFINES_SVH
`define CRCP_DEFINES_SVH
// register byte offsets
`define CRCP_OFS_COMMAND 8'h00
`define CRCP_OFS_FIFO_DATA 8'h04
`define CRCP_OFS_FIFO_LEVEL 8'h08
`define CRCP_OFS_PRIMARY_STATUS 8'h0c
`define CRCP_OFS_ERROR_CAUSE 8'h10
`define CRCP_OFS_REDUNDANCY 8'h14
`define CRCP_OFS_PRESET_LOW 8'h18
`define CRCP_OFS_PRESET_HIGH 8'h1c
`define CRCP_OFS_RESULT_LOW 8'h20
`define CRCP_OFS_RESULT_HIGH 8'h24
`define CRCP_OFS_IRQ_STATUS 8'h28
`define CRCP_OFS_IRQ_MASK 8'h2c
// command codes
`define CRCP_CMD_IDLE 6'h00
`define CRCP_CMD_CALC 6'h12
// redundancy config fields
`define CRCP_RED_WIDTH8 0
`define CRCP_RED_ALG3309 1
`define CRCP_RED_MSBFIRST 2
// error cause fields
`define CRCP_ERR_ACCESS 0
`define CRCP_ERR_OVERFLOW 1
`define CRCP_ERR_CRC 2
`define CRCP_ERR_FRAMING 3
`define CRCP_ERR_COLLISION 4
// irq status fields
`define CRCP_IRQ_TX 0
`define CRCP_IRQ_ERR 1
// primary status fields
`define CRCP_PST_ERR 0
`define CRCP_PST_DONE 1
`define CRCP_PST_BUSY 2
// polynomials (implicit top term dropped) and reset values
`define CRCP_POLY8 8'h1d
`define CRCP_POLY16 16'h1021
`define CRCP_RESID16_3309 16'hf0b8
`define CRCP_RESET_PRESET_LOW 8'hff
`define CRCP_RESET_PRESET_HIGH 8'hff
`define CRCP_RESET_REDUNDANCY 8'h00
`define CRCP_FIFO_DEPTH 64
`define CRCP_FIFO_AW 6
`define CRCP_RESP_OKAY 2'b00
`define CRCP_RESP_SLVERR 2'b10
`endif

// ---- rtl/crcp_pkg.sv ----
// types for the fifo crc coprocessor
// assumes crcp_defines.svh on the include path
`include "crcp_defines.svh"
package crcp_pkg;
   typedef enum logic [1:0] {
      CRCP_IDLE = 2'b01,
      CRCP_CALC = 2'b10
   } crcp_mode_e;
   typedef struct packed {
      logic awvalid;
      logic [7:0] awaddr;
      logic wvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bready;
      logic arvalid;
      logic [7:0] araddr;
      logic rready;
   } crcp_axi_req_s;
   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } crcp_axi_rsp_s;
   typedef struct packed {
      crcp_axi_rsp_s rsp;
      logic aw_held;
      logic [7:0] aw_addr;
      logic w_held;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      crcp_mode_e mode;
      logic [`CRCP_FIFO_AW-1:0] rd_ptr;
      logic [`CRCP_FIFO_AW-1:0] wr_ptr;
      logic [`CRCP_FIFO_AW:0] count;
      logic [15:0] crc;
      logic [7:0] redundancy;
      logic [7:0] preset_low;
      logic [7:0] preset_high;
      logic done;
      logic [4:0] err_cause;
      logic [1:0] irq_status;
      logic [1:0] irq_mask;
      logic irq;
   } crcp_state_s;
endpackage : crcp_pkg

// ---- rtl/crcp_top.sv ----
// fifo crc coprocessor: axi4-lite registers, byte fifo, crc engine
// assumes one 100 MHz clock, synchronous active low reset, one host master
// assumes the host reads results only after the done flag is seen set
//
// The register offsets and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "crcp_defines.svh"
module crcp_top (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write address
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [7:0] s_axi_awaddr,
   // axi4-lite write data
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   // axi4-lite write response
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   output logic [1:0] s_axi_bresp,
   // axi4-lite read address
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   input wire logic [7:0] s_axi_araddr,
   // axi4-lite read data
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   // interrupt
   output logic irq
);
   import crcp_pkg::*;

   // ----------------------------------------------------------------
   // state and fifo storage
   // ----------------------------------------------------------------
   crcp_state_s st_reg;
   crcp_state_s st_next;
   logic [7:0] fifo_mem [0:`CRCP_FIFO_DEPTH-1];
   logic fifo_push;
   logic [7:0] fifo_head;

   // fifo head read is combinational from the array
   // pointers wrap at the array size; the count keeps one extra bit so
   // that a full fifo and an empty one never look alike
   assign fifo_head = fifo_mem[st_reg.rd_ptr];

   // one byte through the crc, either width, either bit order
   // serial form on purpose: eight chained shifts fit in one cycle at this
   // rate and keep the bit order choice plain to see
   // no final inversion: the result is the raw register contents
   function automatic logic [15:0] crcp_step(input logic [15:0] c,
         input logic [7:0] d, input logic w8, input logic msb);
      logic [15:0] r;
      logic b;
      r = c;
      for (int i = 0; i < 8; i++) begin
         b = msb ? d[7-i] : d[i];
         if (w8) begin
            r[7:0] = {r[6:0], 1'b0} ^ ((r[7] ^ b) ? `CRCP_POLY8 : 8'h00);
            r[15:8] = 8'h00;
         end else begin
            r = {r[14:0], 1'b0} ^ ((r[15] ^ b) ? `CRCP_POLY16 : 16'h0000);
         end
      end
      return r;
   endfunction : crcp_step

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      logic wr_go;
      logic rd_go;
      logic ovl;
      logic cmd_wr;
      logic consume;
      logic [15:0] pre;
      logic [15:0] res;
      logic crc_bad;
      logic [31:0] rv;
      logic tx_set;
      wr_go = 1'b0;
      rd_go = 1'b0;
      ovl = 1'b0;
      cmd_wr = 1'b0;
      consume = 1'b0;
      pre = {st_reg.preset_high, st_reg.preset_low};
      res = 16'h0000;
      crc_bad = 1'b0;
      rv = 32'h0000_0000;
      tx_set = 1'b0;
      fifo_push = 1'b0;
      st_next = st_reg;

      // ------------------------------------------------------------
      // write channel: take address and data in either order
      // ------------------------------------------------------------
      // each half is parked until the other arrives; both readies stay
      // low until the response is taken, so one write is in flight
      if (s_axi_awvalid && st_reg.rsp.awready) begin
         st_next.aw_held = 1'b1;
         st_next.aw_addr = s_axi_awaddr;
         st_next.rsp.awready = 1'b0;
      end
      if (s_axi_wvalid && st_reg.rsp.wready) begin
         st_next.w_held = 1'b1;
         st_next.w_data = s_axi_wdata;
         st_next.w_strb = s_axi_wstrb;
         st_next.rsp.wready = 1'b0;
      end
      wr_go = st_reg.aw_held && st_reg.w_held && !st_reg.rsp.bvalid;
      if (st_reg.rsp.bvalid && s_axi_bready) begin
         st_next.rsp.bvalid = 1'b0;
         st_next.rsp.awready = 1'b1;
         st_next.rsp.wready = 1'b1;
      end

      // ------------------------------------------------------------
      // read channel: decode in the cycle the address is accepted, answer one cycle later
      // ------------------------------------------------------------
      // the address is decoded live, so no address register is kept;
      // limitation: no second read is taken before rready is seen
      if (s_axi_arvalid && st_reg.rsp.arready) begin
         rd_go = 1'b1;
         st_next.rsp.arready = 1'b0;
      end
      if (st_reg.rsp.rvalid && s_axi_rready) begin
         st_next.rsp.rvalid = 1'b0;
         st_next.rsp.arready = 1'b1;
      end

      // ------------------------------------------------------------
      // crc engine consumes one byte per cycle while calc is active
      // ------------------------------------------------------------
      // the command never touches the read pointer, so bytes written before
      // it started are taken first; an empty fifo idles the engine and raises done
      if (st_reg.mode == CRCP_CALC && st_reg.count != '0) begin
         consume = 1'b1;
         st_next.crc = crcp_step(st_reg.crc, fifo_head,
            st_reg.redundancy[`CRCP_RED_WIDTH8],
            st_reg.redundancy[`CRCP_RED_MSBFIRST]);
         st_next.rd_ptr = st_reg.rd_ptr + 1'b1;
         st_next.done = 1'b0;
      end
      // the check looks at the crc after the last byte, so a message that
      // carries its own check bytes ends on the expected residue
      // done rises once the fifo is drained during calc
      if (st_reg.mode == CRCP_CALC && st_reg.count == '0
            && !st_reg.done) begin
         st_next.done = 1'b1;
         tx_set = 1'b1;
         // 16-bit 3309 checks residue; 8-bit and legacy expect zero remainder
         if (st_reg.redundancy[`CRCP_RED_WIDTH8])
            crc_bad = st_reg.crc[7:0] != 8'h00;
         else if (st_reg.redundancy[`CRCP_RED_ALG3309])
            crc_bad = st_reg.crc != `CRCP_RESID16_3309;
         else
            crc_bad = st_reg.crc != 16'h0000;
         st_next.err_cause[`CRCP_ERR_CRC] = crc_bad;
      end

      // ------------------------------------------------------------
      // register writes
      // ------------------------------------------------------------
      // only lane zero is used: every register is one byte wide
      if (wr_go) begin
         st_next.rsp.bvalid = 1'b1;
         st_next.rsp.bresp = `CRCP_RESP_OKAY;
         st_next.aw_held = 1'b0;
         st_next.w_held = 1'b0;
         unique case (st_reg.aw_addr)
            `CRCP_OFS_COMMAND: cmd_wr = st_reg.w_strb[0];
            `CRCP_OFS_FIFO_DATA: begin
               if (st_reg.w_strb[0]) begin
                  // the count's top bit alone marks a full fifo; a byte
                  // written then is dropped, the oldest data is kept
                  if (st_reg.count[`CRCP_FIFO_AW]) begin
                     ovl = 1'b1;
                  end else begin
                     fifo_push = 1'b1;
                     st_next.wr_ptr = st_reg.wr_ptr + 1'b1;
                     st_next.done = 1'b0;
                  end
               end
            end
            `CRCP_OFS_REDUNDANCY:
               if (st_reg.w_strb[0]) st_next.redundancy = st_reg.w_data[7:0];
            `CRCP_OFS_PRESET_LOW:
               if (st_reg.w_strb[0]) st_next.preset_low = st_reg.w_data[7:0];
            `CRCP_OFS_PRESET_HIGH:
               if (st_reg.w_strb[0]) st_next.preset_high = st_reg.w_data[7:0];
            `CRCP_OFS_ERROR_CAUSE: ;
            `CRCP_OFS_IRQ_STATUS:
               if (st_reg.w_strb[0])
                  st_next.irq_status = st_reg.irq_status
                     & ~st_reg.w_data[1:0];
            `CRCP_OFS_IRQ_MASK:
               if (st_reg.w_strb[0]) st_next.irq_mask = st_reg.w_data[1:0];
            default: st_next.rsp.bresp = `CRCP_RESP_SLVERR;
         endcase
      end
      // a completion in the clearing cycle still sets the flag: the host
      // would otherwise miss the interrupt for that command
      if (tx_set)
         st_next.irq_status[`CRCP_IRQ_TX] = 1'b1;

      // ------------------------------------------------------------
      // command start and stop, only by host write
      // ------------------------------------------------------------
      // trade-off: an unknown code stops the engine instead of being
      // ignored, so a stray write cannot leave calc running unseen
      if (cmd_wr) begin
         if (st_reg.w_data[5:0] == `CRCP_CMD_CALC) begin
            st_next.mode = CRCP_CALC;
            st_next.crc = st_reg.redundancy[`CRCP_RED_WIDTH8]
               ? {8'h00, pre[7:0]} : pre;
            st_next.done = 1'b0;
            st_next.err_cause = 5'h00; // new command clears causes
         end else if (st_reg.w_data[5:0] == `CRCP_CMD_IDLE) begin
            st_next.mode = CRCP_IDLE;
         end else begin
            // unsupported code: flagged as access error
            st_next.mode = CRCP_IDLE;
            st_next.err_cause[`CRCP_ERR_ACCESS] = 1'b1;
         end
      end

      // ------------------------------------------------------------
      // error causes and the error interrupt bit
      // ------------------------------------------------------------
      // limitation: framing and collision causes have no source here, no
      // receiver is attached, so they always read as zero
      // overflow set wins over a command clearing causes
      if (ovl)
         st_next.err_cause[`CRCP_ERR_OVERFLOW] = 1'b1;
      if (st_next.err_cause != 5'h00)
         st_next.irq_status[`CRCP_IRQ_ERR] = 1'b1;

      // fifo occupancy
      // a push is refused while full, so the count never passes the depth
      st_next.count = st_reg.count + (fifo_push ? 1'b1 : 1'b0)
         - (consume ? 1'b1 : 1'b0);

      // ------------------------------------------------------------
      // register reads
      // ------------------------------------------------------------
      // the result registers follow the crc register at all times; they
      // are only meaningful once done is set
      if (rd_go) begin
         st_next.rsp.rvalid = 1'b1;
         st_next.rsp.rresp = `CRCP_RESP_OKAY;
         res = st_reg.crc;
         unique case (s_axi_araddr)
            `CRCP_OFS_COMMAND:
               rv = {26'h0, st_reg.mode == CRCP_CALC ? `CRCP_CMD_CALC
                  : `CRCP_CMD_IDLE};
            `CRCP_OFS_FIFO_DATA: rv = 32'h0; // calc returns no data
            `CRCP_OFS_FIFO_LEVEL: rv = {25'h0, st_reg.count};
            `CRCP_OFS_PRIMARY_STATUS: begin
               rv[`CRCP_PST_ERR] = st_reg.err_cause != 5'h00;
               rv[`CRCP_PST_DONE] = st_reg.done;
               rv[`CRCP_PST_BUSY] = st_reg.mode == CRCP_CALC;
            end
            `CRCP_OFS_ERROR_CAUSE: rv = {27'h0, st_reg.err_cause};
            `CRCP_OFS_REDUNDANCY: rv = {24'h0, st_reg.redundancy};
            `CRCP_OFS_PRESET_LOW: rv = {24'h0, st_reg.preset_low};
            `CRCP_OFS_PRESET_HIGH: rv = {24'h0, st_reg.preset_high};
            `CRCP_OFS_RESULT_LOW: rv = {24'h0, res[7:0]};
            `CRCP_OFS_RESULT_HIGH: rv = {24'h0, res[15:8]};
            `CRCP_OFS_IRQ_STATUS: rv = {30'h0, st_reg.irq_status};
            `CRCP_OFS_IRQ_MASK: rv = {30'h0, st_reg.irq_mask};
            default: st_next.rsp.rresp = `CRCP_RESP_SLVERR;
         endcase
         st_next.rsp.rdata = rv;
      end

      // level interrupt from unmasked sticky bits
      // taken from the next state so irq registers together with the flags
      st_next.irq = |(st_next.irq_status & st_next.irq_mask);
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   // fifo array has no reset: contents meaningless until written
   always_ff @(posedge aclk) begin
      if (fifo_push)
         fifo_mem[st_reg.wr_ptr] <= st_reg.w_data[7:0];
   end

   // whole state captured once per cycle
   // reset writes zeros first, then the few fields with other values
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_reg <= '0;
         st_reg.rsp.awready <= 1'b1;
         st_reg.rsp.wready <= 1'b1;
         st_reg.rsp.arready <= 1'b1;
         st_reg.mode <= CRCP_IDLE;
         st_reg.redundancy <= `CRCP_RESET_REDUNDANCY;
         st_reg.preset_low <= `CRCP_RESET_PRESET_LOW;
         st_reg.preset_high <= `CRCP_RESET_PRESET_HIGH;
      end else begin
         st_reg <= st_next;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   // outputs straight from state flops
   assign s_axi_awready = st_reg.rsp.awready;
   assign s_axi_wready = st_reg.rsp.wready;
   assign s_axi_bvalid = st_reg.rsp.bvalid;
   assign s_axi_bresp = st_reg.rsp.bresp;
   assign s_axi_arready = st_reg.rsp.arready;
   assign s_axi_rvalid = st_reg.rsp.rvalid;
   assign s_axi_rdata = st_reg.rsp.rdata;
   assign s_axi_rresp = st_reg.rsp.rresp;
   assign irq = st_reg.irq;
endmodule : crcp_top
`default_nettype wire

// ---- test/crcp_properties.sv ----
// checker for the crc coprocessor bus and interrupt ports
// assumes binding to crcp_top; sees its ports only
`timescale 1ns/1ps
`default_nettype none
module crcp_properties (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // write channels
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [1:0] s_axi_bresp,
   // read channels
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   // interrupt
   input wire logic irq
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // ----
   // answers stand until taken, channels blocked meanwhile; answer latency, reset state, upper lanes zero
   // ----
   b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
   r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
   w_block_a: assert property (s_axi_bvalid |->
      !s_axi_awready && !s_axi_wready) else $error("write reopened");
   r_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read reopened");
   rd_latency_a: assert property (s_axi_arvalid && s_axi_arready |=>
      s_axi_rvalid) else $error("read answer late");
   wr_latency_a: assert property (s_axi_awvalid && s_axi_awready &&
      s_axi_wvalid && s_axi_wready |-> ##1 !s_axi_bvalid ##1 s_axi_bvalid)
      else $error("write answer off time");
   reset_state_a: assert property ($rose(aresetn) |-> s_axi_awready &&
      s_axi_arready && !s_axi_rvalid && !irq) else $error("bad reset");
   high_zero_a: assert property (s_axi_rvalid && s_axi_rresp == 2'b00 |->
      s_axi_rdata[31:8] == 24'h0) else $error("upper lanes set");
   // main scenarios reached
   cover property ($rose(irq));
   cover property ($fell(irq));
   cover property (s_axi_rvalid && s_axi_rresp == 2'b10);
endmodule : crcp_properties
bind crcp_top crcp_properties u_props (.aclk, .aresetn, .s_axi_awvalid,
   .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
   .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .irq);
`default_nettype wire

// ---- test/crcp_host_model.sv ----
// host model: axi4-lite master, one transfer at a time
// assumes a slave on aclk that answers within 50 sampled cycles
`timescale 1ns/1ps
`default_nettype none
module crcp_host_model import crcp_pkg::*; (
   // clock
   input wire logic aclk,
   // bus request and answer
   output crcp_pkg::crcp_axi_req_s req,
   input wire crcp_pkg::crcp_axi_rsp_s rsp
);
   initial req = '0;
   // only the host issues commands; readies sampled at negedge
   // so the decision never races the slave's own edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d,
      output bit ok);
      bit aw, wd, ta, tw;
      int n;
      aw = 0;
      wd = 0;
      n = 0;
      @(posedge aclk);
      req.awvalid <= 1'b1;
      req.awaddr <= a;
      req.wvalid <= 1'b1;
      req.wdata <= {24'h0, d};
      req.wstrb <= 4'h1;
      req.bready <= 1'b1;
      while (!(aw && wd) && n < 50) begin
         @(negedge aclk);
         n++;
         ta = req.awvalid && rsp.awready;
         tw = req.wvalid && rsp.wready;
         @(posedge aclk);
         aw |= ta;
         wd |= tw;
         if (ta) req.awvalid <= 1'b0;
         if (tw) req.wvalid <= 1'b0;
      end
      do begin
         @(negedge aclk);
         n++;
      end while (!rsp.bvalid && n < 50);
      @(posedge aclk);
      req.bready <= 1'b0;
      ok = n < 50;
   endtask : wr
   // results are only read once the flags said so
   task automatic rd(input logic [7:0] a, output bit ok);
      int n;
      n = 0;
      @(posedge aclk);
      req.arvalid <= 1'b1;
      req.araddr <= a;
      req.rready <= 1'b1;
      do begin
         @(negedge aclk);
         n++;
      end while (!rsp.arready && n < 50);
      @(posedge aclk);
      req.arvalid <= 1'b0;
      do begin
         @(negedge aclk);
         n++;
      end while (!rsp.rvalid && n < 50);
      @(posedge aclk);
      req.rready <= 1'b0;
      ok = n < 50;
   endtask : rd
endmodule : crcp_host_model
`default_nettype wire

// ---- test/test_fifo_crc_coprocessor_command.sv ----
// self-checking bench for the crc coprocessor
// assumes crcp_top and the host model; one 100 MHz clock
`timescale 1ns/1ps
`default_nettype none
module test_fifo_crc_coprocessor_command;
   import crcp_pkg::*;
   logic aclk = 1'b0;
   logic aresetn;
   logic irq;
   crcp_axi_req_s req;
   wire crcp_axi_rsp_s rsp;
   logic [33:0] q[$];
   logic [33:0] e;
   int fails = 0;
   int n_checks = 0;
   always #5 aclk = ~aclk;
   crcp_host_model host (.aclk(aclk), .req(req), .rsp(rsp));
   crcp_top dut (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awvalid(req.awvalid), .s_axi_awready(rsp.awready),
      .s_axi_awaddr(req.awaddr), .s_axi_wvalid(req.wvalid),
      .s_axi_wready(rsp.wready), .s_axi_wdata(req.wdata),
      .s_axi_wstrb(req.wstrb), .s_axi_bvalid(rsp.bvalid),
      .s_axi_bready(req.bready), .s_axi_bresp(rsp.bresp),
      .s_axi_arvalid(req.arvalid), .s_axi_arready(rsp.arready),
      .s_axi_araddr(req.araddr), .s_axi_rvalid(rsp.rvalid),
      .s_axi_rready(req.rready), .s_axi_rdata(rsp.rdata),
      .s_axi_rresp(rsp.rresp), .irq(irq));
   // reference crc: non-reflected, order bit picks input bit order
   function automatic logic [15:0] step(logic [15:0] c, logic [7:0] d,
      logic [2:0] m);
      logic b;
      for (int i = 0; i < 8; i++) begin
         b = m[2] ? d[7-i] : d[i];
         if (m[0]) c[7:0] = {c[6:0], 1'b0} ^ ((c[7] ^ b) ? 8'h1d : 8'h00);
         else c = {c[14:0], 1'b0} ^ ((c[15] ^ b) ? 16'h1021 : 16'h0000);
      end
      return c;
   endfunction : step
   task automatic chk(input logic [33:0] g, input logic [33:0] x);
      n_checks++;
      if (g !== x) begin
         fails++;
         $display("ERROR %0t got %h expected %h", $time, g, x);
      end
   endtask : chk
   task automatic finish_test;
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : finish_test
   task automatic hang;
      fails++;
      finish_test;
   endtask : hang
   // bus helpers note the expected answer before issuing
   task automatic w(input logic [7:0] a, input logic [7:0] d,
      input logic [1:0] r = 2'b00);
      bit ok;
      q.push_back({r, 32'h0});
      host.wr(a, d, ok);
      if (!ok) hang;
   endtask : w
   task automatic rd(input logic [7:0] a, input logic [7:0] d,
      input logic [1:0] r = 2'b00);
      bit ok;
      q.push_back({r, 24'h0, d});
      host.rd(a, ok);
      if (!ok) hang;
   endtask : rd
   task automatic ci(input logic x);
      @(negedge aclk);
      chk({33'h0, irq}, {33'h0, x});
   endtask : ci
   task automatic wait_irq;
      for (int k = 0; k < 100 && irq !== 1'b1; k++) @(negedge aclk);
      if (irq !== 1'b1) hang;
      ci(1'b1);
   endtask : wait_irq
   // answers compared as they appear; error data is don't care
   always @(negedge aclk) begin
      if ((rsp.bvalid && req.bready) || (rsp.rvalid && req.rready)) begin
         e = q.pop_front();
         if (rsp.bvalid) chk({rsp.bresp, 32'h0}, e);
         else chk({rsp.rresp, e[33] ? e[31:0] : rsp.rdata}, e);
      end
   end
   initial begin
      logic [15:0] c, s;
      logic [7:0] x, m;
      logic v, er;
      aresetn = 1'b0;
      void'($urandom(32'h35f4d9b5));
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      rd(8'h14, 8'h00);
      rd(8'h18, 8'hff);
      rd(8'h1c, 8'hff);
      rd(8'h30, 8'h00, 2'b10);
      w(8'h30, 8'h00, 2'b10);
      w(8'h00, 8'h3f);
      rd(8'h10, 8'h01);
      rd(8'h0c, 8'h01);
      for (int k = 0; k < 65; k++) w(8'h04, k[7:0]);
      rd(8'h08, 8'h40);
      rd(8'h10, 8'h03);
      w(8'h2c, 8'h01);
      w(8'h00, 8'h12);
      wait_irq;
      w(8'h00, 8'h00);
      rd(8'h08, 8'h00);
      $display("test errors and overflow done");
      // every width, variant and order; one byte before start
      for (m = 0; m < 8; m++) begin
         c = 16'($urandom);
         w(8'h14, m);
         w(8'h18, c[7:0]);
         w(8'h1c, c[15:8]);
         x = 8'($urandom);
         w(8'h04, x);
         c = step(c, x, m[2:0]);
         w(8'h00, 8'h12);
         for (int k = 0; k < 1 + m % 3; k++) begin
            x = 8'($urandom);
            w(8'h04, x);
            c = step(c, x, m[2:0]);
         end
         // legacy msb-first runs end in their own crc to hit a pass
         s = c;
         v = m[2] && !m[1];
         if (v && !m[0]) begin
            w(8'h04, s[15:8]);
            c = step(c, s[15:8], m[2:0]);
         end
         x = v ? s[7:0] : 8'($urandom);
         w(8'h28, 8'h03);
         ci(1'b0);
         w(8'h04, x);
         c = step(c, x, m[2:0]);
         wait_irq;
         er = m[0] ? c[7:0] != 0 : c != (m[1] ? 16'hf0b8 : 16'h0);
         rd(8'h20, c[7:0]);
         if (!m[0]) rd(8'h24, c[15:8]);
         rd(8'h0c, {5'h0, 2'b11, er});
         rd(8'h10, {5'h0, er, 2'b00});
         rd(8'h08, 8'h00);
         // an early drain may have left the error bit; it re-sets only now
         w(8'h28, 8'h02);
         rd(8'h28, {6'h0, er, 1'b1});
         w(8'h2c, 8'h00);
         ci(1'b0);
         w(8'h2c, 8'h01);
         ci(1'b1);
         w(8'h28, 8'h01);
         ci(1'b0);
         w(8'h00, 8'h00);
         $display("test mode %0d done", m);
      end
      finish_test;
   end
endmodule : test_fifo_crc_coprocessor_command
`default_nettype wire
